/* dv/pcb_checker.sv */
// port checker for the pll configuration bank
`timescale 1ns/1ps
module pcb_checker (
    // clock and reset
    input wire sys_clk_i,
    input wire srst_i,
    // inputs
    input wire scl_i,
    input wire control_source_mode_i,
    input wire [2:0] sw_config_select_i,
    input wire [2:0] config_select_pin_i,
    // outputs
    input wire sda_o,
    input wire sda_oe_o,
    input wire [3:0] pll_suspend_n_o,
    input wire shutdown_pin_config_o,
    input wire ref_source_select_o,
    input wire [4:0] crystal_cap_trim_o,
    input wire [2:0] active_config_o,
    input wire [6:0] reference_divider_o,
    input wire pll_a_power_down_o,
    input wire [7:0] feedback_divider_low_set4_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    reset_state_a: assert property ($fell(srst_i) |->
        pll_suspend_n_o == 4'hF && !shutdown_pin_config_o && feedback_divider_low_set4_o == 8'h01)
        else $error("bad reset state");
    power_down_a: assert property (pll_a_power_down_o == (reference_divider_o == 7'h00))
        else $error("power down wrong");
    active_range_a: assert property (active_config_o <= 3'h5)
        else $error("active copy out of range");
    sw_select_a: assert property (control_source_mode_i && $stable(control_source_mode_i)
        && $stable(sw_config_select_i) && sw_config_select_i < 3'h6
        |=> active_config_o == $past(sw_config_select_i)) else $error("sw select ignored");
    sw_fold_a: assert property (control_source_mode_i && $stable(control_source_mode_i)
        && $stable(sw_config_select_i) && sw_config_select_i > 3'h5
        |=> active_config_o == 3'h0) else $error("high select not copy 0");
    pin_select_a: assert property ((!control_source_mode_i && $stable(config_select_pin_i)
        && config_select_pin_i < 3'h6)[*8] |=> active_config_o == $past(config_select_pin_i))
        else $error("pin select ignored");
    write_timing_a: assert property ($changed({pll_suspend_n_o, shutdown_pin_config_o,
        ref_source_select_o, crystal_cap_trim_o, feedback_divider_low_set4_o}) |-> !scl_i)
        else $error("setting changed outside a write");
    open_drain_a: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    oe_change_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data changed while clock high");
    cover property (control_source_mode_i && pll_a_power_down_o && active_config_o == 3'h3);
    cover property ($rose(sda_oe_o));
    cover property ($rose(ref_source_select_o));
endmodule // pcb_checker

bind pcb_reg_bank pcb_checker u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .scl_i(scl_i),
    .control_source_mode_i(control_source_mode_i), .sw_config_select_i(sw_config_select_i),
    .config_select_pin_i(config_select_pin_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .pll_suspend_n_o(pll_suspend_n_o), .shutdown_pin_config_o(shutdown_pin_config_o),
    .ref_source_select_o(ref_source_select_o), .crystal_cap_trim_o(crystal_cap_trim_o),
    .active_config_o(active_config_o), .reference_divider_o(reference_divider_o),
    .pll_a_power_down_o(pll_a_power_down_o), .feedback_divider_low_set4_o(feedback_divider_low_set4_o));

/* dv/pcb_host_model.sv */
// serial bus host model that writes and reads the bank
`timescale 1ns/1ps
`include "pcb_defines.vh"
module pcb_host_model (
    // clock
    input wire sys_clk_i,
    // bus pins
    input wire sda_oe_i,
    output reg scl_o,
    output wire sda_o
);
    reg sda_low;
    integer n_nack;
    // pulled-up wire, either party may pull it low
    assign sda_o = (sda_oe_i || sda_low) ? 1'b0 : 1'b1;
    initial begin
        scl_o = 1'b1;
        sda_low = 1'b0;
        n_nack = 0;
    end
    task q;
        repeat (5) @(negedge sys_clk_i);
    endtask
    // long low phase leaves room for the device's synchroniser delay
    task bit_io(input reg b, output reg r);
        begin
            sda_low = !b;
            q;
            scl_o = 1'b1;
            q;
            r = sda_o;
            q;
            scl_o = 1'b0;
            q;
            q;
        end
    endtask
    task start;
        begin
            sda_low = 1'b0;
            q;
            scl_o = 1'b1;
            q;
            sda_low = 1'b1;
            q;
            scl_o = 1'b0;
            q;
        end
    endtask
    task stop;
        begin
            sda_low = 1'b1;
            q;
            scl_o = 1'b1;
            q;
            sda_low = 1'b0;
            q;
        end
    endtask
    task send(input reg [7:0] d);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bit_io(d[i], r);
            bit_io(1'b1, r);
            if (r !== 1'b0)
                n_nack = n_nack + 1;
        end
    endtask
    task wr_reg(input reg [7:0] a, input reg [7:0] d);
        begin
            start;
            send({`PCB_DEV_ADDR, 1'b0});
            send(a);
            send(d);
            stop;
        end
    endtask
    task rd_reg(input reg [7:0] a, output reg [7:0] d);
        integer i;
        reg r;
        begin
            start;
            send({`PCB_DEV_ADDR, 1'b0});
            send(a);
            start;
            send({`PCB_DEV_ADDR, 1'b1});
            for (i = 7; i >= 0; i = i - 1) begin
                bit_io(1'b1, r);
                d[i] = r;
            end
            bit_io(1'b1, r);
            stop;
        end
    endtask
endmodule // pcb_host_model

/* dv/tb.sv */
// self-checking bench for the pll configuration bank
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin n_errors = n_errors + 1; \
    $display("mismatch at %0t got %0h expected %0h", $time, (a), (b)); end end
module tb;
    reg sys_clk_i = 1'b0;
    reg srst_i = 1'b1;
    reg mode = 1'b0;
    reg [2:0] sw_sel = 3'h0;
    reg [2:0] pin_sel = 3'h0;
    wire scl, sda, sda_oe, sda_drv, cz, pd, shdn, refsel;
    wire [3:0] susp_n, rz;
    wire [4:0] trim;
    wire [2:0] act, cp;
    wire [6:0] refdiv;
    wire [7:0] fb;
    integer n_errors = 0;
    integer tests_run = 0;
    integer c;
    reg [7:0] a;
    always #5 sys_clk_i = ~sys_clk_i;
    pcb_reg_bank DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_drv),
        .sda_oe_o(sda_oe), .control_source_mode_i(mode), .sw_config_select_i(sw_sel),
        .config_select_pin_i(pin_sel), .pll_suspend_n_o(susp_n), .shutdown_pin_config_o(shdn),
        .ref_source_select_o(refsel), .crystal_cap_trim_o(trim), .active_config_o(act),
        .loop_zero_cap_select_o(cz), .charge_pump_current_o(cp), .loop_zero_resistor_o(rz),
        .reference_divider_o(refdiv), .pll_a_power_down_o(pd), .feedback_divider_low_set4_o(fb));
    pcb_host_model host (.sys_clk_i(sys_clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    function [7:0] exp_rst(input [7:0] x);
        if (x == 8'h04) exp_rst = 8'h0F;
        else if (x == 8'h05) exp_rst = 8'h04;
        else if (x >= 8'h0A && x <= 8'h0F) exp_rst = 8'h10;
        else if (x == 8'h16) exp_rst = 8'h01;
        else exp_rst = 8'h00;
    endfunction
    function [7:0] loop_addr(input integer k);
        loop_addr = (k == 4) ? 8'h0A : (k == 5) ? 8'h0B : 8'h0C + k;
    endfunction
    function [6:0] refval(input integer k);
        refval = (k == 3) ? 7'h00 : 7'h7F - k;
    endfunction
    function [7:0] loopval(input integer k);
        loopval = k * 8'h23 + 8'h05;
    endfunction
    task chk_rd(input reg [7:0] x, input reg [7:0] e);
        reg [7:0] d;
        begin
            host.rd_reg(x, d);
            `CHK(d, e)
        end
    endtask
    task chk_active(input integer k);
        begin
            `CHK(act, k[2:0])
            `CHK({cz, cp, rz}, loopval(k))
            `CHK(refdiv, refval(k))
            `CHK(pd, refval(k) == 7'h00)
        end
    endtask
    task done(input reg [8*8-1:0] name);
        $display("test %0s finished", name);
    endtask
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_errors);
            if (n_errors == 0 && tests_run > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        #1_000_000;
        n_errors = n_errors + 1;
        end_sim;
    end
    initial begin
        repeat (4) @(negedge sys_clk_i);
        srst_i = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        `CHK({susp_n, cp, pd}, 8'hF3)
        for (a = 8'h04; a <= 8'h16; a = a + 1)
            chk_rd(a, exp_rst(a));
        done("reset");
        host.wr_reg(8'h04, 8'h80);
        `CHK({susp_n, shdn}, 5'h01)
        host.wr_reg(8'h04, 8'hFF);
        chk_rd(8'h04, 8'h8F);
        host.wr_reg(8'h05, 8'h40);
        `CHK(refsel, 1'b1)
        chk_rd(8'h05, 8'h44);
        host.wr_reg(8'h05, 8'hBB);
        `CHK(refsel, 1'b0)
        host.wr_reg(8'h07, 8'hFF);
        `CHK(trim, 5'h1F)
        chk_rd(8'h07, 8'h1F);
        done("fields");
        for (a = 8'h06; a <= 8'h30; a = a + 8'h01)
            if (a == 8'h06 || a == 8'h08 || a == 8'h09 || a == 8'h30) begin
                host.wr_reg(a, 8'hFF);
                chk_rd(a, 8'h00);
            end
        host.wr_reg(8'h16, 8'h02);
        `CHK(fb, 8'h02)
        chk_rd(8'h16, 8'h02);
        done("rsvd");
        for (c = 0; c < 6; c = c + 1) begin
            host.wr_reg(8'h10 + c, 8'h80 | refval(c));
            host.wr_reg(loop_addr(c), loopval(c));
            chk_rd(8'h10 + c, {1'b0, refval(c)});
        end
        mode = 1'b1;
        for (c = 0; c < 8; c = c + 1) begin
            sw_sel = c;
            repeat (3) @(negedge sys_clk_i);
            chk_active(c > 5 ? 0 : c);
        end
        pin_sel = 3'h3;
        mode = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        chk_active(3);
        `CHK(host.n_nack, 0)
        done("copies");
        end_sim;
    end
endmodule // tb

/* verilog/pcb_defines.vh */
// register offsets, field positions, reset values and configuration copy counts for the pll configuration bank
`ifndef PCB_DEFINES_VH
`define PCB_DEFINES_VH

// serial bus device address, value is arbitrary
`define PCB_DEV_ADDR 7'h6A

// register offsets
`define PCB_ADDR_SUSPEND 8'h04
`define PCB_ADDR_REFSEL 8'h05
`define PCB_ADDR_RSVD_06 8'h06
`define PCB_ADDR_XTRIM 8'h07
`define PCB_ADDR_RSVD_08 8'h08
`define PCB_ADDR_RSVD_09 8'h09
`define PCB_ADDR_LOOP_SET4 8'h0A
`define PCB_ADDR_LOOP_SET5 8'h0B
`define PCB_ADDR_LOOP_SET0 8'h0C
`define PCB_ADDR_LOOP_SET1 8'h0D
`define PCB_ADDR_LOOP_SET2 8'h0E
`define PCB_ADDR_LOOP_SET3 8'h0F
`define PCB_ADDR_REFDIV_SET0 8'h10
`define PCB_ADDR_REFDIV_SET1 8'h11
`define PCB_ADDR_REFDIV_SET2 8'h12
`define PCB_ADDR_REFDIV_SET3 8'h13
`define PCB_ADDR_REFDIV_SET4 8'h14
`define PCB_ADDR_REFDIV_SET5 8'h15
`define PCB_ADDR_FBLOW_SET4 8'h16

// field positions
`define PCB_SHUTDOWN_BIT 7
`define PCB_REFSEL_BIT 6
`define PCB_REFSEL_FIXED_BIT 2
`define PCB_LOOP_CZ_BIT 7

// reset values
`define PCB_RST_SUSPEND_N 4'hF
`define PCB_RST_SHUTDOWN 1'b0
`define PCB_RST_REFSEL 1'b0
`define PCB_RST_XTRIM 5'h00
`define PCB_RST_LOOP 8'h10
`define PCB_RST_REFDIV 7'h00
`define PCB_RST_FBLOW 8'h01

// configuration copies
`define PCB_NUM_CFG 6
`define PCB_LAST_CFG 3'h5

`endif

/* verilog/pcb_i2c_slave.v */
// serial management bus slave that turns bus transfers into register write strobes and read fetches
`timescale 1ns/1ps
`include "pcb_defines.vh"
module pcb_i2c_slave (
    // clock and reset
    input wire sys_clk_i,
    input wire srst_i,
    // bus pins
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output reg sda_oe_o,
    // register side
    output reg wr_en_o,
    output reg [7:0] wr_addr_o,
    output reg [7:0] wr_data_o,
    output wire [7:0] rd_addr_o,
    input wire [7:0] rd_data_i
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_REG = 3'd2;
    localparam ST_WR = 3'd3;
    localparam ST_RD = 3'd4;
    localparam ST_ACK = 3'd5;
    localparam ST_MACK = 3'd6;

    reg [2:0] scl_s;
    reg [2:0] sda_s;
    reg scl_f;
    reg sda_f;
    reg scl_d;
    reg sda_d;
    reg [2:0] state;
    reg [2:0] after;
    reg [3:0] cnt;
    reg [7:0] sr;
    reg [7:0] tx;
    reg [7:0] ptr;
    wire scl_rise;
    wire scl_fall;
    wire start_seen;
    wire stop_seen;

    // open drain: only ever pull low
    assign sda_o = 1'b0;
    assign rd_addr_o = ptr;
    assign scl_rise = scl_f & ~scl_d;
    assign scl_fall = ~scl_f & scl_d;
    assign start_seen = scl_f & scl_d & sda_d & ~sda_f;
    assign stop_seen = scl_f & scl_d & ~sda_d & sda_f;

    // three stage sync, level moves only when the last two stages agree
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[1:0], scl_i};
            sda_s <= {sda_s[1:0], sda_i};
            if (scl_s[1] == scl_s[2]) begin
                scl_f <= scl_s[2];
            end
            if (sda_s[1] == sda_s[2]) begin
                sda_f <= sda_s[2];
            end
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
            after <= ST_IDLE;
            cnt <= 4'h0;
            sr <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            sda_oe_o <= 1'b0;
            wr_en_o <= 1'b0;
            wr_addr_o <= 8'h00;
            wr_data_o <= 8'h00;
        end else begin
            wr_en_o <= 1'b0;
            if (start_seen) begin
                state <= ST_ADDR;
                cnt <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_seen) begin
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                if (state == ST_ADDR || state == ST_REG || state == ST_WR) begin
                    sr <= {sr[6:0], sda_f};
                    cnt <= cnt + 4'h1;
                end else if (state == ST_MACK && sda_f) begin
                    // master nack ends the read burst
                    state <= ST_IDLE;
                end
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR, ST_REG, ST_WR: begin
                        if (cnt == 4'h8) begin
                            cnt <= 4'h0;
                            state <= ST_ACK;
                            sda_oe_o <= 1'b1;
                            if (state == ST_ADDR) begin
                                after <= sr[0] ? ST_RD : ST_REG;
                                if (sr[7:1] != `PCB_DEV_ADDR) begin
                                    state <= ST_IDLE;
                                    sda_oe_o <= 1'b0;
                                end
                            end else if (state == ST_REG) begin
                                ptr <= sr;
                                after <= ST_WR;
                            end else begin
                                wr_en_o <= 1'b1;
                                wr_addr_o <= ptr;
                                wr_data_o <= sr;
                                ptr <= ptr + 8'h01;
                                after <= ST_WR;
                            end
                        end
                    end
                    ST_ACK, ST_MACK: begin
                        if (after == ST_RD) begin
                            // fetch on the falling edge so the first bit is set up before scl rises
                            state <= ST_RD;
                            tx <= rd_data_i;
                            sda_oe_o <= ~rd_data_i[7];
                            cnt <= 4'h1;
                            ptr <= ptr + 8'h01;
                        end else begin
                            state <= after;
                            sda_oe_o <= 1'b0;
                            cnt <= 4'h0;
                        end
                    end
                    ST_RD: begin
                        if (cnt == 4'h8) begin
                            sda_oe_o <= 1'b0;
                            state <= ST_MACK;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            sda_oe_o <= ~tx[6];
                            cnt <= cnt + 4'h1;
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // pcb_i2c_slave

/* verilog/pcb_reg_bank.v */
// configuration register bank for the first pll and shared reference settings
// Operation
// R1 - four active-low pll suspend bits, reset to ones so all pll_suspend_n run
// R2 - shutdown pin configuration bit held in top bit of suspend register
// R3 - reference source bit: zero picks crystal, one picks external input clock
// R4 - five-bit crystal load trim kept in low bits, driven to capacitor array
// R5 - seven-bit reference divider in six copies at 0x10 to 0x15, top reserved
// R6 - reference divider value is used directly as ratio, up to 127
// R7 - first pll powers down when active reference divider is zero
// R8 - feedback divider low byte for configuration four at 0x16, reset 01
// R9 - six loop registers 0x0A-0x0F: zero cap, pump current, zero resistor, reset 10
// R10 - three-bit select picks the active configuration copy in software mode
// R11 - host programs full feedback divider only within 2 to 4095; the bank stores any written value without a range check
// R12 - reserved bits and registers read zero and ignore writes; bit 2 of 0x05 reads one
`timescale 1ns/1ps
`include "pcb_defines.vh"
module pcb_reg_bank (
    // clock and reset
    input wire sys_clk_i,
    input wire srst_i,
    // serial management bus pins
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    // configuration selection
    input wire control_source_mode_i,
    input wire [2:0] sw_config_select_i,
    input wire [2:0] config_select_pin_i,
    // shared analog controls
    output reg [3:0] pll_suspend_n_o,
    output reg shutdown_pin_config_o,
    output reg ref_source_select_o,
    output reg [4:0] crystal_cap_trim_o,
    // first pll, active configuration, plus the configuration four feedback divider low byte
    output reg [2:0] active_config_o,
    output reg loop_zero_cap_select_o,
    output reg [2:0] charge_pump_current_o,
    output reg [3:0] loop_zero_resistor_o,
    output reg [6:0] reference_divider_o,
    output reg pll_a_power_down_o,
    output reg [7:0] feedback_divider_low_set4_o
);
    wire wr_en;
    wire [7:0] wr_addr;
    wire [7:0] wr_data;
    wire [7:0] rd_addr;
    reg [7:0] rd_data;

    reg [3:0] suspend_n;
    reg shutdown_cfg;
    reg ref_sel;
    reg [4:0] cap_trim;
    reg [7:0] fb_low4;
    wire [7:0] loop_q [0:`PCB_NUM_CFG-1];
    wire [6:0] refdiv_q [0:`PCB_NUM_CFG-1];

    reg [2:0] pin_s0;
    reg [2:0] pin_s1;
    reg [2:0] pin_s2;
    reg [2:0] pin_sel;
    reg [2:0] next_cfg;

    pcb_i2c_slave u_bus (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data)
    );

    // shared single registers; only defined fields are stored
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            suspend_n <= `PCB_RST_SUSPEND_N; // R1
            shutdown_cfg <= `PCB_RST_SHUTDOWN;
            ref_sel <= `PCB_RST_REFSEL;
            cap_trim <= `PCB_RST_XTRIM;
            fb_low4 <= `PCB_RST_FBLOW; // R8
        end else if (wr_en) begin
            case (wr_addr)
                `PCB_ADDR_SUSPEND: begin
                    suspend_n <= wr_data[3:0]; // R1
                    shutdown_cfg <= wr_data[`PCB_SHUTDOWN_BIT]; // R2
                end
                `PCB_ADDR_REFSEL: begin
                    ref_sel <= wr_data[`PCB_REFSEL_BIT]; // R3
                end
                `PCB_ADDR_XTRIM: begin
                    cap_trim <= wr_data[4:0]; // R4
                end
                `PCB_ADDR_FBLOW_SET4: begin
                    fb_low4 <= wr_data; // R8
                end
                default: begin
                    // reserved and foreign addresses are dropped
                    cap_trim <= cap_trim; // R12
                end
            endcase
        end
    end

    // one storage slice per configuration copy
    genvar c;
    generate
        for (c = 0; c < `PCB_NUM_CFG; c = c + 1) begin : g_cfg
            // loop registers sit in order 4,5,0,1,2,3
            localparam integer LOOP_OFS = (c >= 4) ? (`PCB_ADDR_LOOP_SET4 + c - 4) : (`PCB_ADDR_LOOP_SET0 + c);
            localparam integer REF_OFS = `PCB_ADDR_REFDIV_SET0 + c;
            // offsets fit in one byte, the cut to the bus address width is intended
            localparam [7:0] LOOP_ADDR = LOOP_OFS[7:0];
            localparam [7:0] REF_ADDR = REF_OFS[7:0];
            reg [7:0] loop_r;
            reg [6:0] ref_r;
            always @(posedge sys_clk_i) begin
                if (srst_i) begin
                    loop_r <= `PCB_RST_LOOP; // R9
                    ref_r <= `PCB_RST_REFDIV; // R5
                end else if (wr_en) begin
                    if (wr_addr == LOOP_ADDR) begin
                        loop_r <= wr_data; // R9
                    end
                    if (wr_addr == REF_ADDR) begin
                        ref_r <= wr_data[6:0]; // R5
                    end
                end
            end
            assign loop_q[c] = loop_r;
            assign refdiv_q[c] = ref_r;
        end
    endgenerate

    // read mux, unused bits and unmapped offsets return zero, except bit 2 of 0x05 which reads one
    always @* begin
        rd_data = 8'h00; // R12
        case (rd_addr)
            `PCB_ADDR_SUSPEND: rd_data = {shutdown_cfg, 3'b000, suspend_n}; // R2
            `PCB_ADDR_REFSEL: begin
                rd_data[`PCB_REFSEL_BIT] = ref_sel; // R3
                // fixed one keeps the printed default of this register visible
                rd_data[`PCB_REFSEL_FIXED_BIT] = 1'b1;
            end
            `PCB_ADDR_XTRIM: rd_data = {3'b000, cap_trim}; // R4
            `PCB_ADDR_LOOP_SET4: rd_data = loop_q[4];
            `PCB_ADDR_LOOP_SET5: rd_data = loop_q[5];
            `PCB_ADDR_LOOP_SET0: rd_data = loop_q[0];
            `PCB_ADDR_LOOP_SET1: rd_data = loop_q[1];
            `PCB_ADDR_LOOP_SET2: rd_data = loop_q[2];
            `PCB_ADDR_LOOP_SET3: rd_data = loop_q[3];
            `PCB_ADDR_REFDIV_SET0: rd_data = {1'b0, refdiv_q[0]}; // R5
            `PCB_ADDR_REFDIV_SET1: rd_data = {1'b0, refdiv_q[1]};
            `PCB_ADDR_REFDIV_SET2: rd_data = {1'b0, refdiv_q[2]};
            `PCB_ADDR_REFDIV_SET3: rd_data = {1'b0, refdiv_q[3]};
            `PCB_ADDR_REFDIV_SET4: rd_data = {1'b0, refdiv_q[4]};
            `PCB_ADDR_REFDIV_SET5: rd_data = {1'b0, refdiv_q[5]};
            `PCB_ADDR_FBLOW_SET4: rd_data = fb_low4;
            default: rd_data = 8'h00; // R12
        endcase
    end

    // select pins come from outside, filtered like the bus pins
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            pin_s0 <= 3'h0;
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_sel <= 3'h0;
        end else begin
            pin_s0 <= config_select_pin_i;
            pin_s1 <= pin_s0;
            pin_s2 <= pin_s1;
            if (pin_s1 == pin_s2) begin
                pin_sel <= pin_s2;
            end
        end
    end

    // codes 6 and 7 have no copy behind them, fall back to copy 0
    always @* begin
        next_cfg = control_source_mode_i ? sw_config_select_i : pin_sel; // R10
        if (next_cfg > `PCB_LAST_CFG) begin
            next_cfg = 3'h0;
        end
    end

    // outputs are registered so the analog side never sees decode glitches
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            pll_suspend_n_o <= `PCB_RST_SUSPEND_N;
            shutdown_pin_config_o <= `PCB_RST_SHUTDOWN;
            ref_source_select_o <= `PCB_RST_REFSEL;
            crystal_cap_trim_o <= `PCB_RST_XTRIM;
            active_config_o <= 3'h0;
            loop_zero_cap_select_o <= 1'b0;
            // matches the pump field of the loop register default, so no step after reset
            charge_pump_current_o <= 3'h1; // R9
            loop_zero_resistor_o <= 4'h0;
            reference_divider_o <= `PCB_RST_REFDIV;
            pll_a_power_down_o <= 1'b1;
            feedback_divider_low_set4_o <= `PCB_RST_FBLOW;
        end else begin
            pll_suspend_n_o <= suspend_n; // R1
            shutdown_pin_config_o <= shutdown_cfg; // R2
            ref_source_select_o <= ref_sel; // R3
            crystal_cap_trim_o <= cap_trim; // R4
            active_config_o <= next_cfg; // R10
            loop_zero_cap_select_o <= loop_q[next_cfg][`PCB_LOOP_CZ_BIT]; // R9
            charge_pump_current_o <= loop_q[next_cfg][6:4]; // R9
            loop_zero_resistor_o <= loop_q[next_cfg][3:0]; // R9
            reference_divider_o <= refdiv_q[next_cfg]; // R6
            pll_a_power_down_o <= (refdiv_q[next_cfg] == 7'h00); // R7
            // feedback divider range is the host's duty and is not checked here
            feedback_divider_low_set4_o <= fb_low4; // R11
        end
    end
endmodule // pcb_reg_bank
